// [hw/vmd_map.svh]
// register offsets, field positions, reset values of the monitor dac block
`ifndef VMD_MAP_SVH
`define VMD_MAP_SVH

// ************************************************************
// register indices (byte address is four times the index)
// ************************************************************
`define VMD_ONE_CTRL_IDX   12'h0f4
`define VMD_TWO_CTRL_IDX   12'h0f6
`define VMD_STATUS_IDX     12'h0f8
`define VMD_IDX_TO_BYTE    12'h004

// ************************************************************
// field positions, channel one control
// ************************************************************
`define VMD_ONE_ADDR_W     14'd12
`define VMD_ONE_POL_BIT    12
`define VMD_ONE_FRAC_LSB   13
`define VMD_ONE_EXP_LSB    17

// ************************************************************
// field positions, channel two control
// ************************************************************
`define VMD_TWO_ADDR_W     14'd14
`define VMD_TWO_POL_BIT    14
`define VMD_TWO_FRAC_LSB   15
`define VMD_TWO_EXP_LSB    19

// ************************************************************
// status register layout
// ************************************************************
`define VMD_STAT_TWO_LSB   16

// ************************************************************
// reset values and scaling constants
// ************************************************************
`define VMD_ADDR_RST       14'h0000
`define VMD_POL_RST        1'b0
`define VMD_FRAC_RST       4'h8
`define VMD_ONE_EXP_RST    4'h8
`define VMD_TWO_EXP_RST    4'h0
`define VMD_FRAC_SHIFT     3
`define VMD_EXP_MAX        31

`endif

// [hw/vmd_monitor_dac.sv]
// apb register file and output codes of the two monitor dac channels
`timescale 1ns/1ns
`include "vmd_map.svh"

// Overview of operation
// - channel one address bits 11-0, rw, zero
// - channel two address bits 13-0, rw, zero
// - channel one polarity bit 12, write-only
// - channel two polarity bit 14, write-only
// - polarity zero: bipolar with 1.5 V offset
// - unipolar: 0 pu gives 0 V
// - bipolar: -1 pu gives 0 V
// - +1 pu gives 3 V full scale
// - channel two fraction bits 18-15, eighths, 8h
// - fraction zero selects power-of-two scaling
// - channel two exponent bits 22-19, two^n
// - exponent used only when fraction zero
// - channel one fraction 16-13, exponent 20-17
module vmd_monitor_dac #(
    parameter int VAR_W  = 32,
    parameter int PU_LSB = 24,
    parameter int DAC_W  = 12
) (
    // clock, reset, enable
    input  wire logic             CLK,
    input  wire logic             RESET,
    input  wire logic             CE,
    // apb slave
    input  wire logic             PSEL,
    input  wire logic             PENABLE,
    input  wire logic             PWRITE,
    input  wire logic [11:0]      PADDR,
    input  wire logic [31:0]      PWDATA,
    output logic      [31:0]      PRDATA,
    output logic                  PREADY,
    output logic                  PSLVERR,
    // variable fetch
    output logic      [11:0]      MON_ONE_VAR_ADDRESS,
    output logic      [13:0]      MON_TWO_VAR_ADDRESS,
    input  wire logic [VAR_W-1:0] VAR_ONE_DATA,
    input  wire logic [VAR_W-1:0] VAR_TWO_DATA,
    // output codes
    output logic      [DAC_W-1:0] MONITOR_OUT_ONE,
    output logic      [DAC_W-1:0] MONITOR_OUT_TWO,
    output logic                  MON_ONE_SAT,
    output logic                  MON_TWO_SAT
);

    // ************************************************************
    // elaboration checks
    // ************************************************************
    // codes sit in 16-bit status halves, and the normalising
    // shift must not turn negative; refused while elaborating
    if (DAC_W < 1 || DAC_W > 16) begin : g_bad_dac_w
        $error("DAC_W must lie in 1..16");
    end
    if (PU_LSB < DAC_W || PU_LSB >= VAR_W) begin : g_bad_pu_lsb
        $error("PU_LSB must lie in DAC_W..VAR_W-1");
    end

    // ************************************************************
    // byte addresses of the registers
    // ************************************************************
    localparam logic [11:0] ONE_ADDR =
        `VMD_ONE_CTRL_IDX * `VMD_IDX_TO_BYTE;
    localparam logic [11:0] TWO_ADDR =
        `VMD_TWO_CTRL_IDX * `VMD_IDX_TO_BYTE;
    localparam logic [11:0] STAT_ADDR =
        `VMD_STATUS_IDX * `VMD_IDX_TO_BYTE;

    // ************************************************************
    // reset values
    // ************************************************************
    localparam vmd_pkg::vmd_chan_cfg_t ONE_RST = '{
        pow2_exponent : `VMD_ONE_EXP_RST,
        frac_scale    : `VMD_FRAC_RST,
        polarity_sel  : `VMD_POL_RST,
        var_address   : `VMD_ADDR_RST
    };
    // exponent reset is undefined; zero is used
    localparam vmd_pkg::vmd_chan_cfg_t TWO_RST = '{
        pow2_exponent : `VMD_TWO_EXP_RST,
        frac_scale    : `VMD_FRAC_RST,
        polarity_sel  : `VMD_POL_RST,
        var_address   : `VMD_ADDR_RST
    };
    localparam vmd_pkg::vmd_state_t RST_STATE = '{
        one     : ONE_RST,
        two     : TWO_RST,
        bus     : vmd_pkg::VMD_IDLE,
        prdata  : 32'h0000_0000,
        pready  : 1'b0,
        pslverr : 1'b0,
        out_one : 16'h0000,
        out_two : 16'h0000,
        sat_one : 1'b0,
        sat_two : 1'b0
    };

    // ************************************************************
    // helper functions
    // ************************************************************
    // true for any of the three mapped words
    function automatic logic is_mapped(input logic [11:0] a);
        return (a == ONE_ADDR) || (a == TWO_ADDR) ||
               (a == STAT_ADDR);
    endfunction

    // store one control word; bits above the fields drop out
    function automatic vmd_pkg::vmd_chan_cfg_t wr_cfg(
        input logic [31:0] wd,
        input logic [13:0] aw,
        input int          pol,
        input int          fl,
        input int          el
    );
        vmd_pkg::vmd_chan_cfg_t c;
        c               = '0;
        c.var_address   = wd[13:0] &
                          ((14'h0001 << aw) - 14'h0001);
        c.polarity_sel  = wd[pol];
        c.frac_scale    = wd[fl +: 4];
        c.pow2_exponent = wd[el +: 4];
        return c;
    endfunction

    // only the address reads back; write-only and reserved
    // bits read as zero
    function automatic logic [31:0] rd_cfg(
        input vmd_pkg::vmd_chan_cfg_t c
    );
        return {18'h00000, c.var_address};
    endfunction

    // ************************************************************
    // state and datapath signals
    // ************************************************************
    vmd_pkg::vmd_state_t st_q;      // registered state
    vmd_pkg::vmd_state_t st_d;      // next state
    logic [DAC_W-1:0]    code_one;  // channel one mapped code
    logic [DAC_W-1:0]    code_two;  // channel two mapped code
    logic                sat_one;   // channel one clipped
    logic                sat_two;   // channel two clipped
    logic [31:0]         status;    // live status word

    // ************************************************************
    // datapath, one scaler per channel
    // ************************************************************
    vmd_scaler #(
        .VAR_W  (VAR_W),
        .PU_LSB (PU_LSB),
        .DAC_W  (DAC_W)
    ) u_scale_one (
        .var_value (VAR_ONE_DATA),
        .cfg       (st_q.one),
        .code      (code_one),
        .sat       (sat_one)
    );

    vmd_scaler #(
        .VAR_W  (VAR_W),
        .PU_LSB (PU_LSB),
        .DAC_W  (DAC_W)
    ) u_scale_two (
        .var_value (VAR_TWO_DATA),
        .cfg       (st_q.two),
        .code      (code_two),
        .sat       (sat_two)
    );

    // status shows the codes currently on the outputs
    assign status = {st_q.out_two, st_q.out_one};

    // ************************************************************
    // next-state logic
    // ************************************************************
    // pready comes from a flop, so every access takes one wait
    // state; the write lands on the edge that samples pready
    always_comb begin
        st_d = st_q;

        // codes follow the fetched data one edge later
        st_d.out_one = 16'(code_one);
        st_d.out_two = 16'(code_two);
        st_d.sat_one = sat_one;
        st_d.sat_two = sat_two;

        unique case (st_q.bus)
            vmd_pkg::VMD_IDLE: begin
                st_d.pready  = 1'b0;
                st_d.pslverr = 1'b0;
                // access phase seen: answer on the next edge
                if (PSEL && PENABLE) begin
                    st_d.bus     = vmd_pkg::VMD_ACK;
                    st_d.pready  = 1'b1;
                    st_d.pslverr = !is_mapped(PADDR);
                    st_d.prdata  = 32'h0000_0000;
                    if (!PWRITE) begin
                        if (PADDR == ONE_ADDR) begin
                            st_d.prdata = rd_cfg(st_q.one);
                        end else if (PADDR == TWO_ADDR) begin
                            st_d.prdata = rd_cfg(st_q.two);
                        end else if (PADDR == STAT_ADDR) begin
                            st_d.prdata = status;
                        end
                    end
                end
            end
            vmd_pkg::VMD_ACK: begin
                // master samples pready here; commit the write
                st_d.bus     = vmd_pkg::VMD_IDLE;
                st_d.pready  = 1'b0;
                st_d.pslverr = 1'b0;
                if (PSEL && PENABLE && PWRITE) begin
                    if (PADDR == ONE_ADDR) begin
                        st_d.one = wr_cfg(PWDATA,
                            `VMD_ONE_ADDR_W,
                            `VMD_ONE_POL_BIT,
                            `VMD_ONE_FRAC_LSB,
                            `VMD_ONE_EXP_LSB);
                    end else if (PADDR == TWO_ADDR) begin
                        st_d.two = wr_cfg(PWDATA,
                            `VMD_TWO_ADDR_W,
                            `VMD_TWO_POL_BIT,
                            `VMD_TWO_FRAC_LSB,
                            `VMD_TWO_EXP_LSB);
                    end
                    // status and unmapped writes are dropped
                end
            end
            default: begin
                // illegal code: fall back to idle quietly
                st_d.bus     = vmd_pkg::VMD_IDLE;
                st_d.pready  = 1'b0;
                st_d.pslverr = 1'b0;
            end
        endcase
    end

    // ************************************************************
    // state register
    // ************************************************************
    // reset wins over the enable, so a frozen block still resets;
    // with CE low the bus also stalls, pready never rises
    always_ff @(posedge CLK) begin
        if (RESET) begin
            st_q <= RST_STATE;
        end else if (CE) begin
            st_q <= st_d;
        end
    end

    // ************************************************************
    // outputs, all straight from the state flops
    // ************************************************************
    assign PRDATA              = st_q.prdata;
    assign PREADY              = st_q.pready;
    assign PSLVERR             = st_q.pslverr;
    assign MON_ONE_VAR_ADDRESS = st_q.one.var_address[11:0];
    assign MON_TWO_VAR_ADDRESS = st_q.two.var_address;
    assign MONITOR_OUT_ONE     = st_q.out_one[DAC_W-1:0];
    assign MONITOR_OUT_TWO     = st_q.out_two[DAC_W-1:0];
    assign MON_ONE_SAT         = st_q.sat_one;
    assign MON_TWO_SAT         = st_q.sat_two;

endmodule

// [hw/vmd_pkg.sv]
// types shared by the monitor dac block
package vmd_pkg;

    // ************************************************************
    // per-channel configuration
    // ************************************************************
    typedef struct packed {
        logic [3:0]  pow2_exponent; // power-of-two exponent
        logic [3:0]  frac_scale;    // factor in eighths, 0 = pow2
        logic        polarity_sel;  // 1 unipolar, 0 bipolar
        logic [13:0] var_address;   // variable to observe
    } vmd_chan_cfg_t;

    // ************************************************************
    // apb handshake states, gray along idle -> ack
    // ************************************************************
    typedef enum logic [1:0] {
        VMD_IDLE = 2'b00,
        VMD_ACK  = 2'b01
    } vmd_bus_t;

    // ************************************************************
    // whole state of the top module
    // ************************************************************
    typedef struct packed {
        vmd_chan_cfg_t one;       // channel one config
        vmd_chan_cfg_t two;       // channel two config
        vmd_bus_t      bus;       // slave handshake state
        logic [31:0]   prdata;    // read data
        logic          pready;    // access done
        logic          pslverr;   // unmapped address
        logic [15:0]   out_one;   // channel one code
        logic [15:0]   out_two;   // channel two code
        logic          sat_one;   // channel one clipped
        logic          sat_two;   // channel two clipped
    } vmd_state_t;

endpackage

// [hw/vmd_scaler.sv]
// scaling and range mapping of one monitored variable
`timescale 1ns/1ns
`include "vmd_map.svh"

module vmd_scaler #(
    parameter int VAR_W  = 32,
    parameter int PU_LSB = 24,
    parameter int DAC_W  = 12
) (
    // variable and its configuration
    input  wire logic signed [VAR_W-1:0] var_value,
    input  wire vmd_pkg::vmd_chan_cfg_t  cfg,
    // mapped result
    output logic             [DAC_W-1:0] code,
    output logic                         sat
);

    // room for the largest factor, 2 to the 15
    localparam int SW = VAR_W + 17;
    localparam logic signed [SW-1:0] PU  = SW'(1) <<< PU_LSB;
    localparam logic signed [SW-1:0] MAX = (SW'(1) <<< DAC_W) - SW'(1);

    // ************************************************************
    // saturating clamp onto the code range
    // ************************************************************
    function automatic logic [DAC_W:0] clamp(
        input logic signed [SW-1:0] n
    );
        logic [DAC_W:0] r;
        r = '0;
        if (n < 0) begin
            r = {1'b1, {DAC_W{1'b0}}};
        end else if (n > MAX) begin
            r = {1'b1, {DAC_W{1'b1}}};
        end else begin
            r = {1'b0, n[DAC_W-1:0]};
        end
        return r;
    endfunction

    logic signed [SW-1:0] ext;      // sign extended variable
    logic signed [SW-1:0] scaled;   // variable times factor
    logic signed [SW-1:0] norm;     // scaled onto code units
    logic        [DAC_W:0] clip;    // flag and code

    // ************************************************************
    // scale, offset, map
    // ************************************************************
    always_comb begin
        ext = SW'(var_value);
        if (cfg.frac_scale != 4'h0) begin
            // eighths; exponent is ignored here
            scaled = (ext * $signed({1'b0, cfg.frac_scale}))
                     >>> `VMD_FRAC_SHIFT;
        end else begin
            scaled = ext <<< cfg.pow2_exponent;
        end
        if (cfg.polarity_sel) begin
            // 0 pu at code zero, no offset
            norm = scaled >>> (PU_LSB - DAC_W);
        end else begin
            // mid-scale offset, -1 pu at code zero
            norm = (scaled + PU) >>> (PU_LSB + 1 - DAC_W);
        end
        clip = clamp(norm);
        code = clip[DAC_W-1:0];
        sat  = clip[DAC_W];
    end

endmodule

// [verif/variable_monitor_dac_config_tb_top.sv]
// self-checking bench of the monitor dac register block
`timescale 1ns/1ns
module variable_monitor_dac_config_tb_top;
    // ****************************************
    // signals, addresses, case table
    // ****************************************
    // byte address is four times the index f4h, f6h, f8h
    localparam logic [11:0] A1 = 12'h3d0;
    localparam logic [11:0] A2 = 12'h3d8;
    localparam logic [11:0] AS = 12'h3e0;
    logic        clk, reset, psel, penable, pwrite, pready, pslverr, er;
    logic        ce;        // clock enable of the design
    logic [11:0] paddr, addr_one, out_one, out_two;
    logic [13:0] addr_two;
    logic [31:0] pwdata, prdata, rd, var_one, var_two;
    logic        sat_one, sat_two;
    logic [12:0] e1, e2;    // expected {clip, code}
    int          bad_count, n_tests, j;
    // polarity, fraction, exponent per case; zero fraction selects 2^exp
    int cs [10][3] = '{'{0,8,0}, '{0,8,0}, '{0,8,0}, '{1,8,0}, '{1,8,0},
                       '{1,8,0}, '{1,4,5}, '{1,0,3}, '{1,15,0}, '{0,0,15}};
    longint vs [10] = '{0, -16777216, 16777216, 0, 16777216, -1,
                        8388608, 1048576, 2097152, 1};

    vmd_monitor_dac #(.VAR_W(32), .PU_LSB(24), .DAC_W(12)) DUT (
        .CLK(clk), .RESET(reset), .CE(ce),
        .PSEL(psel), .PENABLE(penable), .PWRITE(pwrite), .PADDR(paddr),
        .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready),
        .PSLVERR(pslverr), .MON_ONE_VAR_ADDRESS(addr_one),
        .MON_TWO_VAR_ADDRESS(addr_two), .VAR_ONE_DATA(var_one),
        .VAR_TWO_DATA(var_two), .MONITOR_OUT_ONE(out_one),
        .MONITOR_OUT_TWO(out_two), .MON_ONE_SAT(sat_one),
        .MON_TWO_SAT(sat_two));

    // 25 mhz clock
    initial begin
        clk = 1'b0;
        forever #20 clk = ~clk;
    end

    // ****************************************
    // tasks and expected-value helpers
    // ****************************************
    // count every compare, report a miss at once
    task automatic chk(input logic [31:0] seen, input logic [31:0] expv);
        n_tests++;
        if (seen !== expv) begin
            bad_count++;
            $display("wrong value at %0t: got %h expected %h",
                     $time, seen, expv);
        end
    endtask

    // one apb transfer; request held until pready is sampled high
    task automatic apb(input logic wr, input logic [11:0] a,
                       input logic [31:0] wd, output logic [31:0] rdv,
                       output logic erv);
        int n;
        n = 0;
        @(posedge clk);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= wr;
        paddr   <= a;
        pwdata  <= wd;
        @(posedge clk);
        penable <= 1'b1;
        do begin
            @(posedge clk);
            n++;
        end while (pready !== 1'b1 && n < 50);
        if (n >= 50) bad_count++;
        rdv = prdata;
        erv = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask

    // expected code: pu is 2^24, 12-bit output, floor shifts
    function automatic logic [12:0] ex_out(longint v, int p, int f, int e);
        longint s;
        longint n;
        s = (f != 0) ? (v * f) >>> 3 : v <<< e;
        n = (p != 0) ? s >>> 12 : (s + 64'sd16777216) >>> 13;
        if (n < 0) return 13'h1000;
        if (n > 4095) return 13'h1fff;
        return {1'b0, n[11:0]};
    endfunction

    // control word from fields, per channel layout
    function automatic logic [31:0] ctl(bit two, int a, int p, int f, int e);
        if (two) return (e << 19) | (f << 15) | (p << 14) | a;
        return (e << 17) | (f << 13) | (p << 12) | a;
    endfunction

    task automatic end_of_test;
        $display("comparisons %0d mismatches %0d", n_tests, bad_count);
        if (bad_count == 0 && n_tests > 0) $display("verification passed");
        else $display("verification failed");
        $finish;
    endtask

    // ****************************************
    // test sequence
    // ****************************************
    initial begin
        {reset, psel, penable, pwrite, paddr, pwdata} = {1'b1, 47'h0};
        {var_one, var_two, bad_count, n_tests} = '0;
        ce = 1'b1;
        repeat (20) @(posedge clk);
        reset <= 1'b0;
        // reset config is bipolar, eighths of eight: zero gives mid-scale
        repeat (3) @(posedge clk);
        chk(out_one, 12'h800);
        chk(out_two, 12'h800);
        apb(1'b0, A1, 32'h0, rd, er);
        chk(rd, 32'h0);
        apb(1'b0, A2, 32'h0, rd, er);
        chk(rd, 32'h0);
        $display("test reset values done");
        // enable low freezes the codes; they move once it returns
        ce      <= 1'b0;
        var_one <= 32'h0100_0000;
        repeat (4) @(posedge clk);
        chk({sat_one, out_one}, 13'h0800);
        ce <= 1'b1;
        repeat (3) @(posedge clk);
        chk({sat_one, out_one}, 13'h1fff);
        var_one <= 32'h0;
        $display("test clock enable done");
        // write-only and reserved bits read zero, unmapped refused
        apb(1'b1, A1, 32'hffffffff, rd, er);
        apb(1'b0, A1, 32'h0, rd, er);
        chk(rd, 32'h00000fff);
        chk(addr_one, 12'hfff);
        apb(1'b1, A2, 32'hffffffff, rd, er);
        apb(1'b0, A2, 32'h0, rd, er);
        chk(rd, 32'h00003fff);
        chk(addr_two, 14'h3fff);
        apb(1'b0, 12'h100, 32'h0, rd, er);
        chk(er, 1'b1);
        chk(rd, 32'h0);
        $display("test register access done");
        // each channel gets a different case so crossed wiring shows
        for (int i = 0; i < 10; i++) begin
            j = (i + 1) % 10;
            apb(1'b1, A1, ctl(0, i, cs[i][0], cs[i][1], cs[i][2]), rd, er);
            apb(1'b1, A2, ctl(1, 100 + i, cs[j][0], cs[j][1], cs[j][2]),
                rd, er);
            @(posedge clk);
            var_one <= vs[i][31:0];
            var_two <= vs[j][31:0];
            repeat (3) @(posedge clk);
            e1 = ex_out(vs[i], cs[i][0], cs[i][1], cs[i][2]);
            e2 = ex_out(vs[j], cs[j][0], cs[j][1], cs[j][2]);
            chk({sat_one, out_one}, e1);
            chk({sat_two, out_two}, e2);
            chk(addr_two, 100 + i);
            apb(1'b0, AS, 32'h0, rd, er);
            chk(rd, {4'h0, e2[11:0], 4'h0, e1[11:0]});
        end
        $display("test scaling and mapping done");
        end_of_test;
    end

    // cut a hang short
    initial begin
        repeat (5000) @(posedge clk);
        bad_count++;
        end_of_test;
    end
endmodule

bind vmd_monitor_dac vmd_monitor_dac_asserts #(.DAC_W(DAC_W)) u_chk (
    .CLK(CLK), .RESET(RESET), .PSEL(PSEL), .PENABLE(PENABLE),
    .PWRITE(PWRITE), .PADDR(PADDR), .PWDATA(PWDATA), .PRDATA(PRDATA),
    .PREADY(PREADY), .MON_ONE_VAR_ADDRESS(MON_ONE_VAR_ADDRESS),
    .MON_TWO_VAR_ADDRESS(MON_TWO_VAR_ADDRESS),
    .MONITOR_OUT_ONE(MONITOR_OUT_ONE), .MONITOR_OUT_TWO(MONITOR_OUT_TWO),
    .MON_ONE_SAT(MON_ONE_SAT), .MON_TWO_SAT(MON_TWO_SAT));

// [verif/vmd_monitor_dac_asserts.sv]
// concurrent checks on the ports of the monitor dac block
`timescale 1ns/1ns
module vmd_monitor_dac_asserts #(
    parameter int DAC_W = 12
) (
    // clock and reset
    input logic             CLK,
    input logic             RESET,
    // apb slave
    input logic             PSEL,
    input logic             PENABLE,
    input logic             PWRITE,
    input logic [11:0]      PADDR,
    input logic [31:0]      PWDATA,
    input logic [31:0]      PRDATA,
    input logic             PREADY,
    // fetch addresses and codes
    input logic [11:0]      MON_ONE_VAR_ADDRESS,
    input logic [13:0]      MON_TWO_VAR_ADDRESS,
    input logic [DAC_W-1:0] MONITOR_OUT_ONE,
    input logic [DAC_W-1:0] MONITOR_OUT_TWO,
    input logic             MON_ONE_SAT,
    input logic             MON_TWO_SAT
);
    // ****************************************
    // helper logic
    // ****************************************
    logic        xfer;      // transfer completes this cycle
    logic        wr_one;    // channel one control written
    logic        wr_two;    // channel two control written
    logic        rd_one;    // channel one control read
    logic        rd_two;    // channel two control read
    logic [11:0] wd_one_q;  // last address written, one
    logic [13:0] wd_two_q;  // last address written, two

    assign xfer   = PSEL && PENABLE && PREADY;
    assign wr_one = xfer && PWRITE && PADDR == 12'h3d0;
    assign wr_two = xfer && PWRITE && PADDR == 12'h3d8;
    assign rd_one = xfer && !PWRITE && PADDR == 12'h3d0;
    assign rd_two = xfer && !PWRITE && PADDR == 12'h3d8;

    // capture written address; a copy keeps $past out of delayed checks
    always_ff @(posedge CLK) begin
        if (wr_one) begin
            wd_one_q <= PWDATA[11:0];
        end
        if (wr_two) begin
            wd_two_q <= PWDATA[13:0];
        end
    end

    // ****************************************
    // assertions
    // ****************************************
    default clocking @(posedge CLK); endclocking
    default disable iff (RESET);

    AST_ONE_ADDR_WR: assert property (
        wr_one |-> ##[1:2] MON_ONE_VAR_ADDRESS == wd_one_q)
        else $error("channel one address not taken from write");
    AST_TWO_ADDR_WR: assert property (
        wr_two |-> ##[1:2] MON_TWO_VAR_ADDRESS == wd_two_q)
        else $error("channel two address not taken from write");
    AST_ONE_ADDR_HOLD: assert property (
        $changed(MON_ONE_VAR_ADDRESS) |->
        $past(wr_one) || $past(wr_one, 2) || $past(RESET))
        else $error("channel one address moved without a write");
    AST_TWO_ADDR_HOLD: assert property (
        $changed(MON_TWO_VAR_ADDRESS) |->
        $past(wr_two) || $past(wr_two, 2) || $past(RESET))
        else $error("channel two address moved without a write");
    AST_ONE_RD: assert property (
        rd_one |-> PRDATA == {20'h00000, MON_ONE_VAR_ADDRESS})
        else $error("channel one control read data wrong");
    AST_TWO_RD: assert property (
        rd_two |-> PRDATA == {18'h00000, MON_TWO_VAR_ADDRESS})
        else $error("channel two control read data wrong");
    AST_RST_ADDR: assert property (
        $past(RESET) |->
        MON_ONE_VAR_ADDRESS == 12'h000 && MON_TWO_VAR_ADDRESS == 14'h0000)
        else $error("address not zero after reset");
    AST_ONE_SAT: assert property (
        MON_ONE_SAT |-> MONITOR_OUT_ONE == {DAC_W{1'b0}} ||
        MONITOR_OUT_ONE == {DAC_W{1'b1}})
        else $error("channel one clipped off a range end");
    AST_TWO_SAT: assert property (
        MON_TWO_SAT |-> MONITOR_OUT_TWO == {DAC_W{1'b0}} ||
        MONITOR_OUT_TWO == {DAC_W{1'b1}})
        else $error("channel two clipped off a range end");
endmodule
